// ---- rtl/sdb_pkg.sv ----
// sdb_pkg: constants shared by the sense descriptor builder files.
// assumes: byte positions count from the start of descriptor-format sense data.
package sdb_pkg;

    // ==========================================================
    // descriptor byte positions
    localparam logic [5:0] INFO_BASE = 6'h08;
    localparam logic [5:0] CMD_BASE  = 6'h14;
    localparam logic [5:0] SKS_BASE  = 6'h20;
    localparam logic [5:0] RU_BASE   = 6'h28;
    localparam logic [5:0] BC_BASE   = 6'h2C;
    localparam logic [5:0] LAST_POS  = 6'h2F;

    // ==========================================================
    // type codes and additional lengths
    localparam logic [7:0] INFO_TYPE = 8'h00;
    localparam logic [7:0] INFO_LEN  = 8'h0A;
    localparam logic [7:0] CMD_TYPE  = 8'h01;
    localparam logic [7:0] CMD_LEN   = 8'h0A;
    localparam logic [7:0] SKS_TYPE  = 8'h02;
    localparam logic [7:0] SKS_LEN   = 8'h06;
    localparam logic [7:0] RU_TYPE   = 8'h03;
    localparam logic [7:0] RU_LEN    = 8'h02;
    localparam logic [7:0] BC_TYPE   = 8'h05;
    localparam logic [7:0] BC_LEN    = 8'h02;

    // ==========================================================
    // field positions
    localparam int VALID_BIT = 7;
    localparam int FLAG_BIT  = 5;

    // ==========================================================
    // header codes and special cases
    localparam logic [7:0] RESP_CURRENT  = 8'h72;
    localparam logic [7:0] RESP_DEFERRED = 8'h73;
    localparam logic [7:0] OP_REASSIGN   = 8'h07;
    localparam logic [3:0] KEY_ABORTED   = 4'hB;
    localparam logic [7:0] ASC_INT_FAIL  = 8'h44;

    // ==========================================================
    // reset values
    localparam logic [7:0] RESP_RESET = 8'h72;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        SDB_IDLE  = 2'b00,
        SDB_CHECK = 2'b01,
        SDB_SEND  = 2'b11,
        SDB_DRAIN = 2'b10
    } sdb_state_e;

    // byte k of a big-endian 8-byte field, k = 0 is the most significant
    function automatic logic [7:0] sdb_get_byte(input logic [63:0] f, input logic [2:0] k);
        logic [5:0] sh;
        sh = {~k, 3'b000};
        return f[sh +: 8];
    endfunction : sdb_get_byte

endpackage : sdb_pkg

// ---- rtl/sdb_lba_check.sv ----
// sdb_lba_check: registered test that a reported block address lies in the command's range.
// assumes: inputs are held stable by the caller for the cycle after they change.
`timescale 1ns/1ps
`default_nettype none
module sdb_lba_check (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [63:0] lba,
    input  wire logic [63:0] cmd_lba,
    input  wire logic [31:0] cmd_blocks,
    output logic             in_range
);
    // ==========================================================
    // range compare
    logic [63:0] offset;
    logic        above;

    // the difference only counts when the lower bound holds, so no wrap can fake a hit
    assign above  = (lba >= cmd_lba);
    assign offset = lba - cmd_lba;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            in_range <= 1'b0;
        end else begin
            in_range <= above && (offset < {32'h0000_0000, cmd_blocks});
        end
    end
endmodule : sdb_lba_check
`default_nettype wire

// ---- rtl/sdb_byte_mux.sv ----
// sdb_byte_mux: selects one byte of descriptor bytes 8 to 47 by position.
// assumes: all field inputs are captured values that stay stable during a frame.
`timescale 1ns/1ps
`default_nettype none
module sdb_byte_mux (
    input  wire logic [5:0]  pos,
    input  wire logic        info_valid_bit,
    input  wire logic [63:0] info_field,
    input  wire logic [31:0] cmd_info,
    input  wire logic [23:0] key_specific_bytes,
    input  wire logic [7:0]  replaceable_unit_code,
    input  wire logic        len_flag_bit,
    output logic [7:0]       byte_out
);
    // ==========================================================
    // byte select; anything not named below is reserved and reads zero
    always_comb begin
        logic [5:0] rel;
        rel      = 6'h00;
        byte_out = 8'h00;
        if (pos >= sdb_pkg::INFO_BASE && pos < sdb_pkg::CMD_BASE) begin
            rel = pos - sdb_pkg::INFO_BASE;
            if (rel == 6'h00) begin
                byte_out = sdb_pkg::INFO_TYPE;
            end else if (rel == 6'h01) begin
                byte_out = sdb_pkg::INFO_LEN;
            end else if (rel == 6'h02) begin
                byte_out[sdb_pkg::VALID_BIT] = info_valid_bit;
            end else if (rel >= 6'h04) begin
                byte_out = sdb_pkg::sdb_get_byte(info_field, 3'(rel - 6'h04));
            end
        end else if (pos >= sdb_pkg::CMD_BASE && pos < sdb_pkg::SKS_BASE) begin
            rel = pos - sdb_pkg::CMD_BASE;
            if (rel == 6'h00) begin
                byte_out = sdb_pkg::CMD_TYPE;
            end else if (rel == 6'h01) begin
                byte_out = sdb_pkg::CMD_LEN;
            end else if (rel >= 6'h04) begin
                byte_out = sdb_pkg::sdb_get_byte({32'h0000_0000, cmd_info},
                                                 3'(rel - 6'h04));
            end
        end else if (pos >= sdb_pkg::SKS_BASE && pos < sdb_pkg::RU_BASE) begin
            rel = pos - sdb_pkg::SKS_BASE;
            unique case (rel)
                6'h00: byte_out = sdb_pkg::SKS_TYPE;
                6'h01: byte_out = sdb_pkg::SKS_LEN;
                6'h04: byte_out = key_specific_bytes[23:16];
                6'h05: byte_out = key_specific_bytes[15:8];
                6'h06: byte_out = key_specific_bytes[7:0];
                default: byte_out = 8'h00;
            endcase
        end else if (pos >= sdb_pkg::RU_BASE && pos < sdb_pkg::BC_BASE) begin
            rel = pos - sdb_pkg::RU_BASE;
            unique case (rel)
                6'h00: byte_out = sdb_pkg::RU_TYPE;
                6'h01: byte_out = sdb_pkg::RU_LEN;
                6'h03: byte_out = replaceable_unit_code;
                default: byte_out = 8'h00;
            endcase
        end else if (pos >= sdb_pkg::BC_BASE && pos <= sdb_pkg::LAST_POS) begin
            rel = pos - sdb_pkg::BC_BASE;
            unique case (rel)
                6'h00: byte_out = sdb_pkg::BC_TYPE;
                6'h01: byte_out = sdb_pkg::BC_LEN;
                6'h03: byte_out[sdb_pkg::FLAG_BIT] = len_flag_bit;
                default: byte_out = 8'h00;
            endcase
        end
    end
endmodule : sdb_byte_mux
`default_nettype wire

// ---- rtl/sdb_builder.sv ----
// sdb_builder: streams descriptor bytes 8 to 47 of descriptor-format sense data.
// assumes: request fields come from logic on sys_clk and hold during the request cycle.
`timescale 1ns/1ps
`default_nettype none
module sdb_builder (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        build_req,
    input  wire logic        deferred_err,
    input  wire logic        info_valid,
    input  wire logic [63:0] fixed_lba,
    input  wire logic [63:0] cmd_lba,
    input  wire logic [31:0] cmd_blocks,
    input  wire logic [7:0]  opcode,
    input  wire logic [3:0]  sense_key,
    input  wire logic [7:0]  asc,
    input  wire logic [31:0] residue,
    input  wire logic        incorrect_length_flag,
    input  wire logic        block_desc_present,
    input  wire logic [31:0] cmd_specific_info,
    input  wire logic [23:0] key_specific_bytes,
    input  wire logic [7:0]  replaceable_unit_code,
    input  wire logic        out_ready,
    output logic             build_busy,
    output logic             out_valid,
    output logic [7:0]       out_data,
    output logic [5:0]       out_pos,
    output logic             out_last,
    output logic [7:0]       response_code,
    output logic             media_loc_ok
);
    // ==========================================================
    // captured request
    sdb_pkg::sdb_state_e state_reg;
    logic        deferred_reg;
    logic        info_valid_reg;
    logic [63:0] lba_reg;
    logic [63:0] cmd_lba_reg;
    logic [31:0] cmd_blocks_reg;
    logic [7:0]  opcode_reg;
    logic [3:0]  key_reg;
    logic [7:0]  asc_reg;
    logic [31:0] residue_reg;
    logic        len_flag_reg;
    logic        bc_present_reg;
    logic [31:0] cmd_info_reg;
    logic [23:0] sks_reg;
    logic [7:0]  ru_reg;
    logic [5:0]  pos_reg;
    logic        build_busy_reg;
    logic        out_valid_reg;
    logic [7:0]  out_data_reg;
    logic [5:0]  out_pos_reg;
    logic        out_last_reg;
    logic [7:0]  response_code_reg;
    logic        media_loc_ok_reg;

    logic        accept;
    logic        load_slot;
    logic        in_range;
    logic        len_flag_sel;
    logic        reassign;
    logic        internal_fail;
    logic        info_valid_bit;
    logic [63:0] info_field;
    logic [7:0]  byte_next;

    assign accept    = build_req && (state_reg == sdb_pkg::SDB_IDLE);
    assign load_slot = !out_valid_reg || out_ready;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            deferred_reg   <= 1'b0;
            info_valid_reg <= 1'b0;
            lba_reg        <= 64'h0;
            cmd_lba_reg    <= 64'h0;
            cmd_blocks_reg <= 32'h0;
            opcode_reg     <= 8'h00;
            key_reg        <= 4'h0;
            asc_reg        <= 8'h00;
            residue_reg    <= 32'h0;
            len_flag_reg   <= 1'b0;
            bc_present_reg <= 1'b0;
            cmd_info_reg   <= 32'h0;
            sks_reg        <= 24'h0;
            ru_reg         <= 8'h00;
        end else if (accept) begin
            deferred_reg   <= deferred_err;
            info_valid_reg <= info_valid;
            lba_reg        <= fixed_lba;
            cmd_lba_reg    <= cmd_lba;
            cmd_blocks_reg <= cmd_blocks;
            opcode_reg     <= opcode;
            key_reg        <= sense_key;
            asc_reg        <= asc;
            residue_reg    <= residue;
            len_flag_reg   <= incorrect_length_flag;
            bc_present_reg <= block_desc_present;
            cmd_info_reg   <= cmd_specific_info;
            sks_reg        <= key_specific_bytes;
            ru_reg         <= replaceable_unit_code;
        end
    end

    // ==========================================================
    // information field selection
    sdb_lba_check u_lba_check (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .lba        (lba_reg),
        .cmd_lba    (cmd_lba_reg),
        .cmd_blocks (cmd_blocks_reg),
        .in_range   (in_range)
    );

    // length flag only counts when the block-command content applies
    assign len_flag_sel  = len_flag_reg && bc_present_reg;
    assign reassign      = (opcode_reg == sdb_pkg::OP_REASSIGN);
    assign internal_fail = (key_reg == sdb_pkg::KEY_ABORTED)
                           && (asc_reg == sdb_pkg::ASC_INT_FAIL);
    // an out-of-range address is withheld as invalid rather than reported wrong, except for a reassign opcode
    assign info_valid_bit = info_valid_reg && (len_flag_sel || in_range || reassign);
    assign info_field     = len_flag_sel ? {{32{residue_reg[31]}}, residue_reg}
                                         : lba_reg;

    sdb_byte_mux u_byte_mux (
        .pos                   (pos_reg),
        .info_valid_bit        (info_valid_bit),
        .info_field            (info_field),
        .cmd_info              (cmd_info_reg),
        .key_specific_bytes    (sks_reg),
        .replaceable_unit_code (ru_reg),
        .len_flag_bit          (len_flag_sel),
        .byte_out              (byte_next)
    );

    // ==========================================================
    // sequencing
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= sdb_pkg::SDB_IDLE;
        end else begin
            unique case (state_reg)
                sdb_pkg::SDB_IDLE:  if (accept) state_reg <= sdb_pkg::SDB_CHECK;
                sdb_pkg::SDB_CHECK: state_reg <= sdb_pkg::SDB_SEND;
                sdb_pkg::SDB_SEND: begin
                    if (load_slot && pos_reg == sdb_pkg::LAST_POS) begin
                        state_reg <= sdb_pkg::SDB_DRAIN;
                    end
                end
                sdb_pkg::SDB_DRAIN: if (out_ready) state_reg <= sdb_pkg::SDB_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pos_reg <= sdb_pkg::INFO_BASE;
        end else if (state_reg == sdb_pkg::SDB_CHECK) begin
            pos_reg <= sdb_pkg::INFO_BASE;
        end else if (state_reg == sdb_pkg::SDB_SEND && load_slot) begin
            pos_reg <= pos_reg + 6'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            build_busy_reg <= 1'b0;
        end else if (accept) begin
            build_busy_reg <= 1'b1;
        end else if (state_reg == sdb_pkg::SDB_DRAIN && out_ready) begin
            build_busy_reg <= 1'b0;
        end
    end

    // ==========================================================
    // output stream; one register stage, stalls hold the byte
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= sdb_pkg::BYTE_RESET;
            out_pos_reg   <= 6'h00;
            out_last_reg  <= 1'b0;
        end else if (state_reg == sdb_pkg::SDB_SEND && load_slot) begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= byte_next;
            out_pos_reg   <= pos_reg;
            out_last_reg  <= (pos_reg == sdb_pkg::LAST_POS);
        end else if (state_reg == sdb_pkg::SDB_DRAIN && out_ready) begin
            out_valid_reg <= 1'b0;
            out_last_reg  <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            response_code_reg <= sdb_pkg::RESP_RESET;
            media_loc_ok_reg  <= 1'b0;
        end else if (state_reg == sdb_pkg::SDB_CHECK) begin
            response_code_reg <= deferred_reg ? sdb_pkg::RESP_DEFERRED
                                              : sdb_pkg::RESP_CURRENT;
            // the address may point near the fault without naming it
            media_loc_ok_reg  <= info_valid_reg && !len_flag_sel
                                 && !internal_fail;
        end
    end

    assign build_busy    = build_busy_reg;
    assign out_valid     = out_valid_reg;
    assign out_data      = out_data_reg;
    assign out_pos       = out_pos_reg;
    assign out_last      = out_last_reg;
    assign response_code = response_code_reg;
    assign media_loc_ok  = media_loc_ok_reg;

    // ==========================================================
    // checks
    a_first_byte_pos: assert property (@(posedge sys_clk) disable iff (reset)
        accept |-> ##3 (out_valid_reg && out_pos_reg == sdb_pkg::INFO_BASE))
        else $error("first byte not at position 8");

    a_order_step: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_ready && !out_last_reg)
        |=> (out_valid_reg && out_pos_reg == $past(out_pos_reg) + 6'h01))
        else $error("byte positions not consecutive");

    a_stall_hold: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && !out_ready)
        |=> (out_valid_reg && $stable(out_data_reg) && $stable(out_pos_reg)))
        else $error("byte changed while stalled");

    a_info_header: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == sdb_pkg::INFO_BASE)
        |-> (out_data_reg == sdb_pkg::INFO_TYPE))
        else $error("information type code wrong");

    a_info_len: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == 6'h09) |-> (out_data_reg == sdb_pkg::INFO_LEN))
        else $error("information length wrong");

    a_info_valid_bit: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == 6'h0A)
        |-> (out_data_reg == {info_valid_bit, 7'h00}))
        else $error("information valid byte wrong");

    a_info_low_byte: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == 6'h13)
        |-> (out_data_reg == (len_flag_sel ? residue_reg[7:0] : lba_reg[7:0])))
        else $error("information field low byte wrong");

    a_cmd_type: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == sdb_pkg::CMD_BASE) |-> (out_data_reg == 8'h01))
        else $error("command descriptor type wrong");

    a_cmd_copy: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == 6'h1F) |-> (out_data_reg == cmd_info_reg[7:0]))
        else $error("command info not copied");

    a_sks_copy: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == 6'h24) |-> (out_data_reg == sks_reg[23:16]))
        else $error("key-specific byte not copied");

    a_sks_type: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == sdb_pkg::SKS_BASE) |-> (out_data_reg == 8'h02))
        else $error("key-specific descriptor type wrong");

    a_ru_copy: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_pos_reg == 6'h2B) |-> (out_data_reg == ru_reg))
        else $error("replaceable-unit code not copied");

    a_bc_flag_byte: assert property (@(posedge sys_clk) disable iff (reset)
        out_last_reg |-> (out_pos_reg == 6'h2F && out_data_reg == {2'b00, len_flag_sel, 5'h00}))
        else $error("block-command byte wrong");

    a_resp_code: assert property (@(posedge sys_clk) disable iff (reset)
        accept |-> ##2 (response_code_reg
                        == ($past(deferred_err, 2) ? 8'h73 : 8'h72)))
        else $error("response code wrong");

    a_media_flag: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && internal_fail) |-> !media_loc_ok_reg)
        else $error("internal failure marked as media location");

    a_busy_release: assert property (@(posedge sys_clk) disable iff (reset)
        (out_valid_reg && out_ready && out_last_reg)
        |=> (!build_busy_reg && !out_valid_reg && state_reg == sdb_pkg::SDB_IDLE))
        else $error("frame did not end after last byte");
endmodule : sdb_builder
`default_nettype wire

// ---- sim/sdb_sink.sv ----
// sdb_sink: far-side byte sink for the descriptor stream, with optional stalls.
// assumes: sdb_builder drives out_* from sys_clk registers.
`timescale 1ns/1ps
`default_nettype none
module sdb_sink (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       stall,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic [5:0] out_pos,
    input  wire logic       out_last,
    output logic            out_ready,
    output logic            order_err
);
    logic [7:0] mem [0:63];
    logic [5:0] nxt_pos_reg;
    int         frames;

    // ==========================================================
    // acceptance: stalls toggle ready so each byte must stand until taken
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall | !out_ready;
        end
    end

    // ==========================================================
    // capture and order tracking; order_err is sticky until reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            nxt_pos_reg <= sdb_pkg::INFO_BASE;
            order_err   <= 1'b0;
            frames      <= 0;
        end else if (out_valid && out_ready) begin
            mem[out_pos] <= out_data;
            if (out_pos !== nxt_pos_reg || out_last !== (nxt_pos_reg == sdb_pkg::LAST_POS)) begin
                order_err <= 1'b1;
            end
            nxt_pos_reg <= out_last ? sdb_pkg::INFO_BASE : nxt_pos_reg + 6'h01;
            if (out_last) begin
                frames <= frames + 1;
            end
        end
    end
endmodule : sdb_sink
`default_nettype wire

// ---- sim/tb_top.sv ----
// tb_top: self-checking bench for sdb_builder, one task per case.
// assumes: sdb_sink takes the bytes; fields hold steady while a frame runs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        build_req = 1'b0;
    logic        deferred_err = 1'b0;
    logic        info_valid = 1'b1;
    logic [63:0] fixed_lba = 64'h0;
    logic [63:0] cmd_lba = 64'h1000;
    logic [31:0] cmd_blocks = 32'h10;
    logic [7:0]  opcode = 8'h0;
    logic [3:0]  sense_key = 4'h0;
    logic [7:0]  asc = 8'h0;
    logic [31:0] residue = 32'h0;
    logic        incorrect_length_flag = 1'b0;
    logic        block_desc_present = 1'b0;
    logic [31:0] cmd_specific_info = 32'h0;
    logic [23:0] key_specific_bytes = 24'h0;
    logic [7:0]  replaceable_unit_code = 8'h0;
    logic        stall = 1'b0;
    logic        out_ready, build_busy, out_valid, out_last, media_loc_ok, order_err;
    logic [7:0]  out_data, response_code;
    logic [5:0]  out_pos;
    int          n_errors = 0;
    int          check_count = 0;

    always #5 sys_clk = ~sys_clk;

    sdb_builder uut (.sys_clk, .reset, .build_req, .deferred_err, .info_valid, .fixed_lba,
        .cmd_lba, .cmd_blocks, .opcode, .sense_key, .asc, .residue, .incorrect_length_flag,
        .block_desc_present, .cmd_specific_info, .key_specific_bytes, .replaceable_unit_code,
        .out_ready, .build_busy, .out_valid, .out_data, .out_pos, .out_last, .response_code,
        .media_loc_ok);
    sdb_sink sink (.sys_clk, .reset, .stall, .out_valid, .out_data, .out_pos, .out_last,
        .out_ready, .order_err);

    // ==========================================================
    // checking and closing
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // one frame: expectation built from the byte map, a refused request mid-frame
    task automatic run_case(input string name, input logic dfr, input logic [63:0] lba,
        input logic [7:0] op, input logic [3:0] key, input logic [7:0] ac,
        input logic [31:0] res, input logic lf, input logic bdp, input logic exp_v,
        input logic [7:0] sd, input logic stl);
        logic [7:0]  exp [0:63];
        logic [63:0] field;
        logic        flag;
        int          i;
        int          w;
        int          f0;
        flag = lf & bdp;
        field = flag ? {{32{res[31]}}, res} : lba;
        for (i = 8; i < 48; i++) exp[i] = 8'h00;
        exp[8] = sdb_pkg::INFO_TYPE;
        exp[9] = sdb_pkg::INFO_LEN;
        exp[10] = {exp_v, 7'h00};
        for (i = 0; i < 8; i++) exp[12+i] = field[63-8*i -: 8];
        exp[20] = sdb_pkg::CMD_TYPE;
        exp[21] = sdb_pkg::CMD_LEN;
        for (i = 0; i < 4; i++) exp[28+i] = {sd[7:4], i[3:0]};
        exp[32] = sdb_pkg::SKS_TYPE;
        exp[33] = sdb_pkg::SKS_LEN;
        exp[36] = sd | 8'h80;
        exp[37] = ~sd;
        exp[38] = sd;
        exp[40] = sdb_pkg::RU_TYPE;
        exp[41] = sdb_pkg::RU_LEN;
        exp[43] = sd ^ 8'h5A;
        exp[44] = sdb_pkg::BC_TYPE;
        exp[45] = sdb_pkg::BC_LEN;
        exp[47] = {2'b00, flag, 5'b00000};
        f0 = sink.frames;
        @(posedge sys_clk);
        {deferred_err, fixed_lba, opcode, sense_key, asc} <= {dfr, lba, op, key, ac};
        {residue, incorrect_length_flag, block_desc_present} <= {res, lf, bdp};
        cmd_specific_info <= {exp[28], exp[29], exp[30], exp[31]};
        key_specific_bytes <= {exp[36], exp[37], exp[38]};
        replaceable_unit_code <= exp[43];
        stall <= stl;
        build_req <= 1'b1;
        w = 0;
        while ((w < 3 || build_busy !== 1'b0) && w < 300) begin
            @(posedge sys_clk);
            build_req <= (w == 8);
            @(negedge sys_clk);
            w++;
        end
        repeat (5) @(negedge sys_clk);
        check("busy after refused request", 1'b0, build_busy);
        check("frames", f0 + 1, sink.frames);
        check("order", 1'b0, order_err);
        check("response code", dfr ? 8'h73 : 8'h72, response_code);
        check("media location", info_valid & ~flag & ~(key == 4'hB && ac == 8'h44),
              media_loc_ok);
        for (i = 8; i < 48; i++) begin
            check($sformatf("byte %0d", i), exp[i], sink.mem[i]);
        end
        $display("test %s done", name);
    endtask : run_case

    task automatic t_in_range();
        run_case("in_range", 1'b0, 64'h100F, 8'h28, 4'h3, 8'h11, 32'h0, 1'b0, 1'b0, 1'b1,
                 8'h31, 1'b1);
    endtask : t_in_range

    task automatic t_residue();
        run_case("residue", 1'b1, 64'h5000, 8'h28, 4'h5, 8'h24, 32'hFFFFFFF0, 1'b1, 1'b1,
                 1'b1, 8'hC2, 1'b0);
    endtask : t_residue

    task automatic t_no_block();
        run_case("no_block", 1'b0, 64'h1000, 8'h28, 4'h3, 8'h11, 32'h44, 1'b1, 1'b0, 1'b1,
                 8'h17, 1'b1);
    endtask : t_no_block

    task automatic t_reassign();
        run_case("reassign", 1'b1, 64'h99990000, 8'h07, 4'h3, 8'h11, 32'h0, 1'b0, 1'b0,
                 1'b1, 8'hA5, 1'b0);
    endtask : t_reassign

    task automatic t_out_range();
        run_case("out_range", 1'b0, 64'h1010, 8'h28, 4'h3, 8'h11, 32'h0, 1'b0, 1'b0, 1'b0,
                 8'h6E, 1'b1);
    endtask : t_out_range

    task automatic t_aborted();
        run_case("aborted", 1'b0, 64'h1004, 8'h2A, 4'hB, 8'h44, 32'h0, 1'b0, 1'b0, 1'b1,
                 8'h0F, 1'b0);
    endtask : t_aborted

    // ==========================================================
    // main sequence and watchdog (six frames need well under 1000 cycles)
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        check("reset response code", sdb_pkg::RESP_RESET, response_code);
        t_in_range();
        t_residue();
        t_no_block();
        t_reassign();
        t_out_range();
        t_aborted();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
